/* File: logic/tdmx_params.svh */
// Purpose: numeric constants of the tdm frame multiplexer
// Assumes: included by bare name from the package and the design
// Notes: definitions only
`ifndef TDMX_PARAMS_SVH
`define TDMX_PARAMS_SVH

// ==========================================================
// frame layout
`define TDMX_FRAME_LAST    5'h1a
`define TDMX_PHASE_HIGH    5'h10
`define TDMX_PHASE_LOW     5'h0b
`define TDMX_SLOT_FBIT     5'h00
`define TDMX_SLOT_BRK0     5'h09
`define TDMX_SLOT_BRK1     5'h12
`define TDMX_SLOT_BRK2     5'h1a
`define TDMX_SLOT_ONE      5'h01

// ==========================================================
// run limit and scrambler
`define TDMX_MAX_RUN       4'ha
`define TDMX_SCR_TAP_A     6
`define TDMX_SCR_TAP_B     5
`define TDMX_SCR_RST       7'h00

// ==========================================================
// reset values
`define TDMX_FBIT_RST      1'b0
`define TDMX_CCLK_RST      1'b0
`define TDMX_PHASE_RST     1'b1
`define TDMX_LAST_RST      1'b0

`endif

/* File: logic/tdmx_pkg.sv */
// Purpose: shared types of the tdm frame multiplexer
// Assumes: tdmx_params.svh holds the numbers
// Notes: slot kinds encoded as a short gray sequence
`include "tdmx_params.svh"

package tdmx_pkg;
   typedef enum logic [1:0] {
      TDMX_SK_FBIT = 2'b00,
      TDMX_SK_DATA = 2'b01,
      TDMX_SK_BRK  = 2'b11
   } tdmx_slot_kind_t;
endpackage : tdmx_pkg

/* File: logic/tdmx_frame_mux.sv */
// Purpose: 27-slot tdm framer with framing bit, scrambler and codec clock
// Assumes: clk is the supplied multiplexer bit clock, one slot per edge
// Notes: a two-entry buffer toward the transmitter; a stall freezes framing
`timescale 1ns/1ps
`include "tdmx_params.svh"

// What this block does
// - frame phase signal is high 16 clocks then low 11, every frame.
// - framing bit holds for one 27-clock frame, then inverts.
// - codec clock runs at half the framing bit frequency.
// - every channel owns fixed slot positions; no slot is shared.
// - scrambled output never holds more than 10 equal bits in a row.
// - incoming channel bits are captured on the rising clock edge.
// - codec receive clock falls near the middle of each demultiplexed bit.
// - unconnected external inputs read as low.
// - per-channel switch picks codec or external data; both ends must match.
// - codec channels get a transmit clock and their data is sampled into slots.
module tdmx_frame_mux
   import tdmx_pkg::*;
#(
   parameter int NUM_CH = 6
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic [NUM_CH-1:0] ext_data,
   input  wire logic [NUM_CH-1:0] ext_present,
   input  wire logic [NUM_CH-1:0] codec_tx_data,
   input  wire logic [NUM_CH-1:0] sel_codec,
   output logic                   codec_tx_clk,
   output logic                   codec_rx_clk,
   output logic                   frame_phase,
   output logic                   fbit,
   output logic                   mux_bit,
   output logic                   tx_data,
   output logic                   tx_valid,
   input  wire logic              tx_ready
);

   // ==========================================================
   // slot decoding
   function automatic tdmx_slot_kind_t slot_kind(input logic [4:0] s);
      if (s == `TDMX_SLOT_FBIT)
         return TDMX_SK_FBIT;
      if (s == `TDMX_SLOT_BRK0 || s == `TDMX_SLOT_BRK1 || s == `TDMX_SLOT_BRK2)
         return TDMX_SK_BRK;
      return TDMX_SK_DATA;
   endfunction : slot_kind

   // data slots are numbered 0..22 skipping overhead slots
   function automatic int slot_chan(input logic [4:0] s);
      int idx;
      idx = 0;
      if (s > `TDMX_SLOT_BRK1)
         idx = int'(s) - 3;
      else if (s > `TDMX_SLOT_BRK0)
         idx = int'(s) - 2;
      else if (s > `TDMX_SLOT_FBIT)
         idx = int'(s) - 1;
      return idx % NUM_CH;
   endfunction : slot_chan

   logic [4:0]        slot;
   logic [4:0]        next_slot;
   logic [6:0]        scr;
   logic              last_out;
   logic [NUM_CH-1:0] ext_samp;
   logic [NUM_CH-1:0] pres_samp;
   logic [NUM_CH-1:0] codec_samp;
   logic [NUM_CH-1:0] sel_samp;
   logic [NUM_CH-1:0] chan_val;
   tdmx_slot_kind_t   kind;
   logic              advance;
   logic              frame_end;
   logic              data_bit;
   logic              scr_bit;
   logic              line_bit;
   logic              pre_bit;
   logic              fifo_in_ready;
   logic              sel_cur;
   logic              codec_cur;
   logic              ext_cur;
   logic              pres_cur;

   // ==========================================================
   // input retiming
   // inputs are synchronous, so a single rank re-times them to clk
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ext_samp   <= '0;
         pres_samp  <= '0;
         codec_samp <= '0;
         sel_samp   <= '0;
      end else begin
         ext_samp   <= ext_data;
         pres_samp  <= ext_present;
         codec_samp <= codec_tx_data;
         sel_samp   <= sel_codec;
      end
   end

   // no pull-down exists on chip, so absence is an explicit flag
   assign chan_val = (sel_samp & codec_samp) |
                     (~sel_samp & ext_samp & pres_samp);

   // per-slot views of the retimed inputs, read by the slot checks
   assign sel_cur   = sel_samp[slot_chan(slot)];
   assign codec_cur = codec_samp[slot_chan(slot)];
   assign ext_cur   = ext_samp[slot_chan(slot)];
   assign pres_cur  = pres_samp[slot_chan(slot)];

   // ==========================================================
   // frame counters
   assign advance   = fifo_in_ready;
   assign frame_end = (slot == `TDMX_FRAME_LAST);
   assign next_slot = frame_end ? `TDMX_SLOT_FBIT : slot + `TDMX_SLOT_ONE;
   assign kind      = slot_kind(slot);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         slot        <= `TDMX_SLOT_FBIT;
         frame_phase <= `TDMX_PHASE_RST;
      end else if (advance) begin
         slot        <= next_slot;
         frame_phase <= (next_slot < `TDMX_PHASE_HIGH);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fbit         <= `TDMX_FBIT_RST;
         codec_tx_clk <= `TDMX_CCLK_RST;
      end else if (advance && frame_end) begin
         fbit <= ~fbit;
         if (!fbit)
            codec_tx_clk <= ~codec_tx_clk;
      end
   end

   // demultiplexed codec bits change on the rising codec edge, so the
   // falling edge sits half a period later, in the middle of the bit
   assign codec_rx_clk = codec_tx_clk;

   // ==========================================================
   // slot multiplexing, scrambling and run breaking
   assign data_bit = chan_val[slot_chan(slot)];
   assign scr_bit  = data_bit ^ scr[`TDMX_SCR_TAP_A] ^ scr[`TDMX_SCR_TAP_B];
   assign pre_bit  = (kind == TDMX_SK_FBIT) ? fbit : data_bit;

   // overhead slots 9, 18, 26 carry the complement of the previous line bit;
   // with the framing bit this caps any run at 10 without touching data
   always_comb begin
      case (kind)
         TDMX_SK_FBIT: line_bit = fbit;
         TDMX_SK_BRK:  line_bit = ~last_out;
         TDMX_SK_DATA: line_bit = scr_bit;
         default:      line_bit = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scr      <= `TDMX_SCR_RST;
         last_out <= `TDMX_LAST_RST;
         mux_bit  <= 1'b0;
      end else if (advance) begin
         last_out <= line_bit;
         mux_bit  <= pre_bit;
         if (kind == TDMX_SK_DATA)
            scr <= {scr[5:0], scr_bit};
      end
   end

   // ==========================================================
   // two-entry output buffer
   logic       buf_mem [2];
   logic       wr_ptr;
   logic       rd_ptr;
   logic [1:0] buf_cnt;
   logic       do_push;
   logic       do_pop;

   assign fifo_in_ready = (buf_cnt != 2'h2);
   assign do_push       = fifo_in_ready;
   assign tx_valid      = (buf_cnt != 2'h0);
   assign do_pop        = tx_valid && tx_ready;
   assign tx_data       = buf_mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr     <= 1'b0;
         rd_ptr     <= 1'b0;
         buf_cnt    <= 2'h0;
         buf_mem[0] <= 1'b0;
         buf_mem[1] <= 1'b0;
      end else begin
         if (do_push) begin
            buf_mem[wr_ptr] <= line_bit;
            wr_ptr          <= ~wr_ptr;
         end
         if (do_pop)
            rd_ptr <= ~rd_ptr;
         buf_cnt <= buf_cnt + {1'b0, do_push} - {1'b0, do_pop};
      end
   end

   // ==========================================================
   // checks
   logic [3:0] run_len;
   logic [4:0] hi_cnt;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         run_len <= 4'h0;
         hi_cnt  <= 5'h00;
      end else begin
         if (advance)
            run_len <= (line_bit == last_out) ? run_len + 4'h1 : 4'h1;
         if (advance && frame_end)
            hi_cnt <= 5'h00;
         else if (advance && frame_phase)
            hi_cnt <= hi_cnt + 5'h01;
      end
   end

   sequence s_wrap;
      advance && frame_end;
   endsequence

   sequence s_phase_fall;
      advance && slot == 5'h0f;
   endsequence

   a_phase_high: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(frame_phase) |-> hi_cnt == `TDMX_PHASE_HIGH)
      else $error("frame phase high count wrong");

   a_phase_edges: assert property (@(posedge clk) disable iff (sys_rst)
      (s_wrap |=> frame_phase) and (s_phase_fall |=> !frame_phase))
      else $error("frame phase edge misplaced");

   a_fbit_frame: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(fbit) |-> $past(advance && frame_end))
      else $error("framing bit changed mid frame");

   a_codec_half: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(codec_tx_clk) |-> $rose(fbit))
      else $error("codec clock not at half framing rate");

   a_fbit_slot: assert property (@(posedge clk) disable iff (sys_rst)
      advance && slot == `TDMX_SLOT_FBIT |=> last_out == $past(fbit))
      else $error("framing slot does not carry framing bit");

   a_run_limit: assert property (@(posedge clk) disable iff (sys_rst)
      run_len <= `TDMX_MAX_RUN)
      else $error("line run longer than ten");

   a_scr_shift: assert property (@(posedge clk) disable iff (sys_rst)
      advance && kind == TDMX_SK_DATA |=> scr[0] == last_out)
      else $error("scrambler did not take line bit");

   a_idle_zero: assert property (@(posedge clk) disable iff (sys_rst)
      (~sel_samp & ~pres_samp & chan_val) == '0)
      else $error("absent channel not read low");

   a_buf_hold: assert property (@(posedge clk) disable iff (sys_rst)
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("buffered word lost under stall");

   sequence s_stall;
      !advance;
   endsequence

   // a full buffer must hold the whole frame state, or a slot would be skipped
   a_frame_freeze: assert property (@(posedge clk) disable iff (sys_rst)
      s_stall |=> $stable(slot) && $stable(fbit) && $stable(scr) && $stable(codec_tx_clk))
      else $error("framing moved while the buffer was full");

   a_brk_invert: assert property (@(posedge clk) disable iff (sys_rst)
      advance && kind == TDMX_SK_BRK |=> last_out != $past(last_out))
      else $error("break slot did not invert the line");

   a_codec_slot: assert property (@(posedge clk) disable iff (sys_rst)
      advance && kind == TDMX_SK_DATA && sel_cur |=> mux_bit == $past(codec_cur))
      else $error("codec bit not placed in its slot");

   a_ext_slot: assert property (@(posedge clk) disable iff (sys_rst)
      advance && kind == TDMX_SK_DATA && !sel_cur |=> mux_bit == $past(ext_cur && pres_cur))
      else $error("external bit not placed in its slot");

   a_slot_bound: assert property (@(posedge clk) disable iff (sys_rst)
      slot <= `TDMX_FRAME_LAST)
      else $error("slot counter past end of frame");

   a_buf_bound: assert property (@(posedge clk) disable iff (sys_rst)
      buf_cnt <= 2'h2)
      else $error("output buffer count out of range");

endmodule : tdmx_frame_mux

/* File: verif/tdmx_tx_sink.sv */
// Purpose: transmitter-side sink model that pulls the framed stream
// Assumes: clk is the bit clock this board supplies to the framer
// Notes: stall pattern keeps ready low 3 of every 7 cycles
`timescale 1ns/1ps
module tdmx_tx_sink (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic stall_en,
   output logic      tx_ready
);
   logic [2:0] cnt;

   // ==========================================================
   // ready pattern
   // the first of three low cycles fills the two-entry buffer; framing then stalls for the other two and the first ready cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt      <= 3'h0;
         tx_ready <= 1'b1;
      end else begin
         cnt      <= (cnt == 3'h6) ? 3'h0 : cnt + 3'h1;
         tx_ready <= !stall_en || (cnt > 3'h2);
      end
   end
endmodule : tdmx_tx_sink

/* File: verif/tdmx_frame_mux_tb.sv */
// Purpose: self-checking bench for the tdm frame multiplexer
// Assumes: inputs constant per stream test; first accepted bit is slot 0
// Notes: reference model rebuilds framing, scrambler and breaker slots
`timescale 1ns/1ps
`include "tdmx_params.svh"
module tdmx_frame_mux_tb;
   import tdmx_pkg::*;
   logic       clk, sys_rst, stall_en, tx_ready;
   logic [5:0] ext_data, ext_present, codec_tx_data, sel_codec;
   logic       codec_tx_clk, codec_rx_clk, frame_phase, fbit, mux_bit, tx_data, tx_valid;
   int         err_total, n_tests, cyc, c;
   logic       q[$];

   // ==========================================================
   // clock, design, partner
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk; // bit clock from the transmitter side
   end
   tdmx_frame_mux u_tdmx_frame_mux (.clk(clk), .sys_rst(sys_rst), .ext_data(ext_data),
      .ext_present(ext_present), .codec_tx_data(codec_tx_data), .sel_codec(sel_codec),
      .codec_tx_clk(codec_tx_clk), .codec_rx_clk(codec_rx_clk), .frame_phase(frame_phase),
      .fbit(fbit), .mux_bit(mux_bit), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready));
   tdmx_tx_sink u_tdmx_tx_sink (.clk(clk), .sys_rst(sys_rst), .stall_en(stall_en),
      .tx_ready(tx_ready));

   always @(posedge clk) begin
      if (sys_rst)
         q.delete();
      else if (tx_valid === 1'b1 && tx_ready === 1'b1)
         q.push_back(tx_data);
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   // ==========================================================
   // helpers
   task automatic chk_bit(input logic g, input logic e);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_bit
   task automatic chk_len(input int g, input int e);
      n_tests++;
      if (g != e) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_len
   task automatic do_reset(input logic [5:0] e, p, cd, s, input logic st);
      @(posedge clk);
      sys_rst       <= 1'b1;
      ext_data      <= e;
      ext_present   <= p;
      codec_tx_data <= cd;
      sel_codec     <= s;
      stall_en      <= st;
      repeat (8) @(posedge clk);
      #1;
      chk_bit(frame_phase, `TDMX_PHASE_RST);
      chk_bit(fbit, `TDMX_FBIT_RST);
      chk_bit(codec_tx_clk, `TDMX_CCLK_RST);
      chk_bit(tx_valid, 1'b0);
      @(posedge clk);
      sys_rst <= 1'b0;
   endtask : do_reset
   function automatic logic pick(input int w);
      return (w == 0) ? frame_phase : (w == 1) ? fbit : codec_tx_clk;
   endfunction : pick
   // lengths of one high and the following low stretch of a signal
   task automatic meas(input int w, input int hi, input int lo);
      int n;
      n = 0;
      while (pick(w) !== 1'b0 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
      while (pick(w) !== 1'b1 && n < 600) begin
         @(posedge clk);
         #1;
         n++;
      end
      for (int v = 1; v >= 0; v--) begin
         n = 0;
         while (pick(w) === v[0] && n < 300) begin
            if (w == 2) chk_bit(codec_rx_clk, v[0]);
            @(posedge clk);
            #1;
            n++;
         end
         chk_len(n, v ? hi : lo);
      end
   endtask : meas

   // ==========================================================
   // scenarios
   task automatic t_timing;
      do_reset(6'h00, 6'h00, 6'h00, 6'h00, 1'b0);
      meas(0, `TDMX_PHASE_HIGH, `TDMX_PHASE_LOW);
      meas(1, 27, 27);
      meas(2, 54, 54);
      $display("test timing done");
   endtask : t_timing
   // receiver stalls 3 of every 7 cycles; the first 120 accepted bits are compared
   task automatic t_stream(input string nm, input logic [5:0] e, p, cd, s);
      int k, sl, j, n, run, mx;
      logic fb, pv, d, x;
      logic [6:0] sc;
      do_reset(e, p, cd, s, 1'b1);
      n = 0;
      while (q.size() < 120 && n < 400) begin
         @(posedge clk);
         n++;
      end
      sl = 0;
      fb = `TDMX_FBIT_RST;
      pv = 1'b0;
      sc = `TDMX_SCR_RST;
      run = 0;
      mx = 0;
      for (k = 0; k < 120; k++) begin
         if (sl == `TDMX_SLOT_FBIT) x = fb;
         else if (sl == `TDMX_SLOT_BRK0 || sl == `TDMX_SLOT_BRK1 || sl == `TDMX_SLOT_BRK2)
            x = ~pv;
         else begin
            j = (sl - 1 - (sl > `TDMX_SLOT_BRK0) - (sl > `TDMX_SLOT_BRK1)) % 6;
            d = s[j] ? cd[j] : (e[j] & p[j]);
            x = d ^ sc[`TDMX_SCR_TAP_A] ^ sc[`TDMX_SCR_TAP_B];
            sc = {sc[5:0], x};
         end
         chk_bit(q[k], x);
         run = (k > 0 && q[k] === q[k-1]) ? run + 1 : 1;
         mx = (run > mx) ? run : mx;
         pv = x;
         fb = (sl == `TDMX_FRAME_LAST) ? ~fb : fb;
         sl = (sl == `TDMX_FRAME_LAST) ? 0 : sl + 1;
      end
      chk_len(mx > `TDMX_MAX_RUN, 0);
      $display("test %s done", nm);
   endtask : t_stream
   // free-running frames; mux_bit shows the unscrambled slot value one edge later
   task automatic t_raw(input logic [5:0] e, p, cd, s);
      int k, sl, j;
      logic fb, x;
      do_reset(e, p, cd, s, 1'b0);
      sl = 0;
      fb = `TDMX_FBIT_RST;
      for (k = 0; k < 54; k++) begin
         @(posedge clk);
         #1;
         if (sl == `TDMX_SLOT_FBIT)
            chk_bit(mux_bit, fb);
         else if (sl != `TDMX_SLOT_BRK0 && sl != `TDMX_SLOT_BRK1 && sl != `TDMX_SLOT_BRK2) begin
            j = (sl - 1 - (sl > `TDMX_SLOT_BRK0) - (sl > `TDMX_SLOT_BRK1)) % 6;
            x = s[j] ? cd[j] : (e[j] & p[j]);
            chk_bit(mux_bit, x);
         end
         fb = (sl == `TDMX_FRAME_LAST) ? ~fb : fb;
         sl = (sl == `TDMX_FRAME_LAST) ? 0 : sl + 1;
      end
      $display("test raw done");
   endtask : t_raw

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   initial begin
      sys_rst = 1'b1;
      stall_en = 1'b0;
      ext_data = 6'h00;
      ext_present = 6'h00;
      codec_tx_data = 6'h00;
      sel_codec = 6'h00;
      t_timing();
      for (c = 0; c < 6; c++) t_stream("slot", 6'h01 << c, 6'h3f, 6'h00, 6'h00);
      t_stream("codec", 6'h00, 6'h00, 6'h3f, 6'h3f);
      t_stream("float", 6'h3f, 6'h00, 6'h00, 6'h00);
      t_stream("mixed", 6'h2a, 6'h3f, 6'h0f, 6'h33);
      t_raw(6'h2d, 6'h1f, 6'h16, 6'h30);
      print_verdict();
   end
endmodule : tdmx_frame_mux_tb
